/* rtl/serial_dac_input_port.v */
// Serial input port of a 16-bit voltage-output converter, device side
`timescale 1ns/100ps
`include "serial_dac_input_port_defines.vh"
// Function
// RULE_01: Words are shifted most significant bit first.
// RULE_02: Data is sampled on falling shift clock edges; host changes on rising.
// RULE_03: Host holds frame select low before first bit and through the transfer.
// RULE_04: Byte hosts keep frame select low across both bytes of a word.
// RULE_05: Load strobe low after a full word moves it to the output register.
// RULE_06: Load strobe tied low updates output when frame select rises after full word.
// RULE_07: SPI hosts use polarity 0, phase 1, host generates shift clock.
// RULE_08: Framed serial hosts use internal clock, active-low frame sync, 16-bit words.
// RULE_09: Device drives serial data out toward the host for readback.
// RULE_10: Host can read converter register contents back on serial data out.
// RULE_11: Shift clock edges are ignored while frame select is high.
module serial_dac_input_port (
  // System
  input wire clk_sys_i,
  input wire sys_rst_i,
  // Serial link from host
  input wire shift_clk_i,
  input wire serial_data_in_i,
  input wire transmit_frame_sync_n_i,
  input wire output_load_strobe_n_i,
  // Readback select: 1 shifts out converter register, 0 chains input word
  input wire readback_sel_i,
  // Serial data back to host
  output reg serial_data_out_o,
  // Converter side
  output reg [15:0] dac_value_o,
  output reg dac_update_o,
  output reg word_ready_o
);

  // Synchroniser pairs; only the second stage of each pair is read by logic
  reg [1:0] sclk_sync_r;
  reg [1:0] sdi_sync_r;
  reg [1:0] fs_sync_r;
  reg [1:0] ld_sync_r;

  // Previous synchronised levels for edge detection
  reg sclk_prev_r;
  reg fs_prev_r;

  // Word assembly state
  reg [15:0] shift_r;
  reg [15:0] shift_nxt;
  reg [4:0] bit_cnt_r;
  reg [4:0] bit_cnt_nxt;

  // Hand-over state between frame end and output update
  reg [15:0] input_reg_r;
  reg full_r;
  reg full_nxt;

  // Serial out state
  reg [15:0] out_shift_r;
  reg [15:0] out_shift_nxt;
  reg sdo_nxt;

  // Falling edge of a synchronised level
  function fell_edge;
    input prev_lvl;
    input cur_lvl;
    begin
      fell_edge = prev_lvl & ~cur_lvl;
    end
  endfunction

  // Rising edge of a synchronised level
  function rose_edge;
    input prev_lvl;
    input cur_lvl;
    begin
      rose_edge = ~prev_lvl & cur_lvl;
    end
  endfunction

  // One bit enters at the bottom, so the first bit ends up on top
  function [15:0] shift_in;
    input [15:0] cur_word;
    input bit_in;
    begin
      shift_in = {cur_word[`NEXT_POS:0], bit_in};
    end
  endfunction

  // Synchronised link levels
  wire sclk_s;
  wire sdi_s;
  wire fs_n_s;
  wire ld_n_s;
  assign sclk_s = sclk_sync_r[1];
  assign sdi_s = sdi_sync_r[1];
  assign fs_n_s = fs_sync_r[1];
  assign ld_n_s = ld_sync_r[1];

  // Edge events, each one clock cycle long
  wire sclk_fall;
  wire sclk_rise;
  wire fs_fall;
  wire fs_rise;
  assign sclk_fall = fell_edge(sclk_prev_r, sclk_s);
  assign sclk_rise = rose_edge(sclk_prev_r, sclk_s);
  assign fs_fall = fell_edge(fs_prev_r, fs_n_s);
  assign fs_rise = rose_edge(fs_prev_r, fs_n_s);

  // Frame qualifiers
  wire word_done;
  wire frame_open;
  wire take_bit;
  wire latch_word;
  wire load_now;
  wire out_step;
  assign word_done = (bit_cnt_r == `CNT_FULL);
  assign frame_open = ~fs_n_s;
  assign take_bit = frame_open & sclk_fall; // see RULE_11
  assign latch_word = fs_rise & word_done; // see RULE_04
  assign load_now = full_r & ~ld_n_s & ~dac_update_o; // see RULE_05 see RULE_06
  // Bit 15 of the readback stands from frame start through the first rising edge
  assign out_step = frame_open & sclk_rise & (bit_cnt_r != `CNT_ZERO);

  // Shift clock synchroniser; idles low like the pin
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sclk_sync_r <= `SYNC_ZERO;
    end else begin
      sclk_sync_r <= {sclk_sync_r[0], shift_clk_i};
    end
  end

  // Serial data synchroniser
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sdi_sync_r <= `SYNC_ZERO;
    end else begin
      sdi_sync_r <= {sdi_sync_r[0], serial_data_in_i};
    end
  end

  // Frame select synchroniser; resets high so no false frame start
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      fs_sync_r <= `SYNC_ONES;
    end else begin
      fs_sync_r <= {fs_sync_r[0], transmit_frame_sync_n_i};
    end
  end

  // Load strobe synchroniser; resets inactive
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ld_sync_r <= `SYNC_ONES;
    end else begin
      ld_sync_r <= {ld_sync_r[0], output_load_strobe_n_i};
    end
  end

  // Edge detector history, reset to the idle levels of the pins
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sclk_prev_r <= 1'b0;
      fs_prev_r <= 1'b1;
    end else begin
      sclk_prev_r <= sclk_s;
      fs_prev_r <= fs_n_s;
    end
  end

  // Next shifter contents and bit count
  // Counter saturates at a full word, so extra edges keep only the last 16 bits
  // Count clears only at frame start, so byte hosts may pause inside a frame
  always @* begin
    shift_nxt = shift_r;
    bit_cnt_nxt = bit_cnt_r;
    if (fs_fall) begin
      bit_cnt_nxt = `CNT_ZERO;
    end else if (take_bit) begin // see RULE_11
      shift_nxt = shift_in(shift_r, sdi_s); // see RULE_01 see RULE_02
      if (!word_done) begin
        bit_cnt_nxt = bit_cnt_r + `CNT_ONE;
      end
    end
  end

  // Shifter and bit counter registers
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      shift_r <= `WORD_ZERO;
      bit_cnt_r <= `CNT_ZERO;
    end else begin
      shift_r <= shift_nxt;
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  // Pending-word flag; a new word wins over the clear in the same cycle
  always @* begin
    full_nxt = full_r;
    if (latch_word) begin
      full_nxt = 1'b1;
    end else if (dac_update_o) begin
      full_nxt = 1'b0;
    end
  end

  // Input register loaded when the frame closes after a full word
  // Short frames leave the previous word untouched
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      input_reg_r <= `WORD_ZERO;
      full_r <= 1'b0;
      word_ready_o <= 1'b0;
    end else begin
      full_r <= full_nxt;
      word_ready_o <= latch_word; // see RULE_04
      if (latch_word) begin
        input_reg_r <= shift_r;
      end
    end
  end

  // Output update: strobe low moves a pending word, tied low gives auto update
  // The update pulse blocks a second move of the same word
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      dac_value_o <= `WORD_ZERO;
      dac_update_o <= 1'b0;
    end else begin
      dac_update_o <= load_now;
      if (load_now) begin // see RULE_05 see RULE_06
        dac_value_o <= input_reg_r;
      end
    end
  end

  // Next serial out: readback of converter register or daisy chain of shifter
  // Changes after rising edges so the host samples it stable on falling edges
  always @* begin
    out_shift_nxt = out_shift_r;
    sdo_nxt = serial_data_out_o;
    if (fs_fall) begin
      out_shift_nxt = readback_sel_i ? dac_value_o : shift_r; // see RULE_10
      sdo_nxt = out_shift_nxt[`MSB_POS];
    end else if (out_step) begin
      out_shift_nxt = shift_in(out_shift_r, 1'b0);
      sdo_nxt = out_shift_r[`NEXT_POS]; // see RULE_09
    end
  end

  // Serial out registers; the pin comes straight from a flip-flop
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      out_shift_r <= `WORD_ZERO;
      serial_data_out_o <= 1'b0;
    end else begin
      out_shift_r <= out_shift_nxt;
      serial_data_out_o <= sdo_nxt;
    end
  end

endmodule

/* rtl/serial_dac_input_port_defines.vh */
// Constants for the serial converter input port
`ifndef SERIAL_DAC_INPUT_PORT_DEFINES_VH
`define SERIAL_DAC_INPUT_PORT_DEFINES_VH
`define WORD_BITS 16
`define CNT_BITS 5
`define CNT_ZERO 5'h00
`define CNT_FULL 5'h10
`define CNT_ONE 5'h01
`define WORD_ZERO 16'h0000
`define SYNC_ZERO 2'h0
`define SYNC_ONES 2'h3
`define MSB_POS 15
`define NEXT_POS 14
`endif

/* verification/dac_port_properties.sv */
// Output checker for the converter port
`timescale 1ns/100ps
module dac_props(
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire transmit_frame_sync_n_i,
  input wire output_load_strobe_n_i,
  input wire word_ready_o,
  input wire dac_update_o,
  input wire serial_data_out_o,
  input wire [15:0] dac_value_o);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // Pins are seen through two sync stages, hence the past depths
  sequence s_auto; word_ready_o ##0 !$past(output_load_strobe_n_i, 2); endsequence
  a_auto_upd: assert property (s_auto |=> dac_update_o) else $error("no update");
  a_upd_ld: assert property (dac_update_o |-> !$past(output_load_strobe_n_i, 3)) else $error("stray");
  a_rdy_pulse: assert property (word_ready_o |=> !word_ready_o) else $error("long ready");
  a_upd_pulse: assert property (dac_update_o |=> !dac_update_o) else $error("long update");
  a_sdo_frame: assert property ($changed(serial_data_out_o) |-> !$past(transmit_frame_sync_n_i, 3))
    else $error("sdo moved outside frame");
  a_val_hold: assert property (!dac_update_o |-> $stable(dac_value_o)) else $error("moved");
endmodule
bind serial_dac_input_port dac_props u_props(.*);

/* verification/host_model.sv */
// Host serial master, 200 ns shift clock
`timescale 1ns/100ps
module host_model(output reg sck_o, sdi_o, fs_n_o, input wire sdo_i, output reg [15:0] rx_o);
  integer i;
  initial {sck_o, sdi_o, fs_n_o, rx_o} = 19'h10000;
  // Gap before each byte; frame stays low
  task xfer(input [15:0] w, input integer n);
    begin
      fs_n_o = 0;
      for (i = 0; i < n; i = i + 1) begin
        #(i % 8 ? 100 : 400) sck_o = 1;
        sdi_o = w[15 - i];
        // Sample on the falling edge, as the port does
        #100 rx_o = {rx_o[14:0], sdo_i};
        sck_o = 0;
      end
      #200 fs_n_o = 1;
      sdi_o = ~sdi_o; // Data line flips to the inverse of the last bit after the frame closes
    end
  endtask
endmodule

/* verification/tb.sv */
// Bench for the converter input port
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_total++; $display("CHECK FAILED %0t %h %h", $time, a, e); end end
module tb;
  reg clk_sys_i = 0, sys_rst_i = 1, ld_n = 1, rb = 0;
  wire sck, sdi, fs_n, serial_data_out;
  wire [15:0] rx, dac;
  wire rdy, upd;
  integer err_total = 0, check_count = 0;
  integer rdy_cnt = 0, upd_cnt = 0;
  // Pulse counters for the one-cycle outputs
  always @(posedge clk_sys_i) begin
    if (rdy) rdy_cnt++;
    if (upd) upd_cnt++;
  end
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  host_model u_host(.sck_o(sck), .sdi_o(sdi), .fs_n_o(fs_n), .sdo_i(serial_data_out), .rx_o(rx));
  serial_dac_input_port u_dut(.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .shift_clk_i(sck), .serial_data_in_i(sdi),
    .transmit_frame_sync_n_i(fs_n), .output_load_strobe_n_i(ld_n), .readback_sel_i(rb), .serial_data_out_o(serial_data_out),
    .dac_value_o(dac), .dac_update_o(upd), .word_ready_o(rdy));
  task summarize;
    begin
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // Frame, then time for the sync flops
  task send(input [15:0] w, input integer n);
    begin
      u_host.xfer(w, n);
      repeat (10) @(negedge clk_sys_i);
    end
  endtask
  // Held word, strobe, auto update, short frame
  task t_load;
    begin
      send(16'ha5c3, 16);
      `CHK(dac, 16'h0000)
      `CHK(rdy_cnt, 1)
      `CHK(upd_cnt, 0)
      ld_n = 0;
      send(16'h3c96, 0);
      `CHK(dac, 16'ha5c3)
      send(16'h3c96, 16);
      `CHK(dac, 16'h3c96)
      send(16'hffff, 8);
      `CHK(dac, 16'h3c96)
      $display("t_load done");
    end
  endtask
  // Readback returns the word held at frame start
  task t_read;
    begin
      rb = 1;
      send(16'h1234, 16);
      `CHK(rx, 16'h3c96)
      `CHK(dac, 16'h1234)
      rb = 0;
      send(16'h0f0f, 16);
      `CHK(rx, 16'h1234)
      `CHK(dac, 16'h0f0f)
      `CHK(rdy_cnt, 4)
      `CHK(upd_cnt, 4)
      $display("t_read done");
    end
  endtask
  initial begin
    repeat (20) @(negedge clk_sys_i);
    sys_rst_i = 0;
    repeat (10) @(negedge clk_sys_i);
    t_load;
    t_read;
    summarize;
  end
  // Watchdog far past both tests
  initial begin
    #100000;
    err_total++;
    summarize;
  end
endmodule
